//--- rtl/eccp_out.v
`timescale 1ns/10ps
`default_nettype none
`include "eccp_out_map.vh"
module eccp_out (
  // clock and reset
  input  wire        CLK,
  input  wire        RST_N,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  // capture pin
  input  wire        CAP_IN,
  // pwm pins, enable low while driving
  output wire        PWM_OUT_A,
  output wire        PWM_OUT_B,
  output wire        PWM_OUT_C,
  output wire        PWM_OUT_D,
  output wire [3:0]  PWM_OE_N,
  // special event trigger pulse
  output wire        TRIG_OUT
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [7:0]  ctrl_ff;      // unit_control_reg
  reg  [15:0] cmp_ff;       // compare_value_pair
  reg  [15:0] t1_ff;        // timer_one_count
  reg  [15:0] t3_ff;        // timer_three_count
  reg  [3:0]  cfg_ff;       // timer enables and select
  reg  [15:0] pwm_ff;       // period low byte, duty high byte
  reg  [3:0]  dir_ff;       // port direction, 0 = output
  reg         flag_ff;      // sticky capture/compare flag
  reg  [15:0] capt_ff;      // captured timer value
  reg  [31:0] prdata_ff;    // read data, loaded in setup
  reg         slverr_ff;    // error, loaded in setup
  reg  [2:0]  sync_ff;      // capture pin synchroniser
  reg         filt_ff;      // agreed pin level
  reg         filt_prev_ff; // level one cycle back
  reg  [3:0]  pre_ff;       // capture prescaler
  reg         eq_ff;        // match seen last cycle
  reg         cmp_pin_ff;   // compare output latch
  reg  [9:0]  t2_ff;        // timer 2 with fine bits
  reg  [9:0]  duty_ff;      // duty latched at period end
  reg         pwm_raw_ff;   // raw pwm waveform
  reg  [3:0]  out_ff;       // pin levels
  reg  [3:0]  oe_n_ff;      // pin enables
  reg         trig_ff;      // trigger pulse

  // ------------------------------------------------------------
  // fields and decode
  // ------------------------------------------------------------
  wire [3:0] unit_mode_select  = ctrl_ff[3:0];
  wire [1:0] pwm_output_config = ctrl_ff[7:6];
  wire       setup   = PSEL & ~PENABLE;   // first apb cycle
  wire       access  = PSEL & PENABLE;    // completes at once
  wire       pwm_md  = (unit_mode_select[3:2] == 2'b11);
  wire       tsel    = cfg_ff[`CFG_TSEL];

  // byte address maps to a register
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a <= `OFS_CAPT) & (a[1:0] == 2'b00);
    end
  endfunction

  // write strobe for one offset; bus signals come in as arguments so it re-evaluates
  function wr_hit;
    input       go;
    input [7:0] a;
    input [7:0] ofs;
    begin
      wr_hit = go & (a == ofs);
    end
  endfunction

  // shared 16-bit timer step: software write, clear, count
  function [15:0] tmr_next;
    input [15:0] cur;
    input        en;
    input        clr;
    input        wr;
    input [15:0] wd;
    begin
      tmr_next = wr ? wd : (clr ? 16'h0000 : (en ? cur + 16'h0001 : cur));
    end
  endfunction

  wire wr_go   = access & PWRITE;  // write in its access cycle
  wire wr_ctrl = wr_hit(wr_go, PADDR, `OFS_CTRL);
  wire wr_cmp  = wr_hit(wr_go, PADDR, `OFS_CMP);
  wire wr_t1   = wr_hit(wr_go, PADDR, `OFS_T1);
  wire wr_t3   = wr_hit(wr_go, PADDR, `OFS_T3);
  wire wr_cfg  = wr_hit(wr_go, PADDR, `OFS_CFG);
  wire wr_pwm  = wr_hit(wr_go, PADDR, `OFS_PWM);
  wire wr_dir  = wr_hit(wr_go, PADDR, `OFS_DIR);
  wire wr_stat = wr_hit(wr_go, PADDR, `OFS_STAT);

  // ------------------------------------------------------------
  // capture and compare events
  // ------------------------------------------------------------
  wire [15:0] sel_tmr = tsel ? t3_ff : t1_ff;
  wire cmp_md = (unit_mode_select == `MODE_CMP_TGL) |
                (unit_mode_select[3:2] == 2'b10);
  wire cap_md = (unit_mode_select[3:2] == 2'b01);
  wire eq     = cmp_md & (sel_tmr == cmp_ff);
  // only the first cycle of a match counts, so a stopped timer
  // sitting on the compare value raises one event, not many
  wire fire   = eq & ~eq_ff;
  wire sp_clr = fire & (unit_mode_select == `MODE_CMP_TRIG);
  wire rise   = filt_ff & ~filt_prev_ff;
  wire fall   = ~filt_ff & filt_prev_ff;
  reg  cap_hit;

  // capture edge choice per mode
  always @* begin
    case (unit_mode_select)
      `MODE_CAP_FALL: cap_hit = fall;
      `MODE_CAP_RISE: cap_hit = rise;
      `MODE_CAP_4:    cap_hit = rise & (pre_ff[1:0] == 2'b11);
      `MODE_CAP_16:   cap_hit = rise & (pre_ff == 4'hf);
      default:        cap_hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // timer 2 pwm time base
  // ------------------------------------------------------------
  wire       t2_run = pwm_md & cfg_ff[`CFG_T2_EN];
  wire       t2_end = (t2_ff == {pwm_ff[7:0], 2'b11});
  reg  [9:0] nxt_t2;
  reg  [9:0] nxt_duty;

  // period is (period+1)*4 cycles; duty reloads at the wrap so a
  // new value never cuts a pulse short mid-period
  always @* begin
    nxt_t2   = t2_ff;
    nxt_duty = duty_ff;
    if (!t2_run) begin
      nxt_t2 = 10'h000;
    end else if (t2_end) begin
      nxt_t2   = 10'h000;
      nxt_duty = {pwm_ff[15:8], ctrl_ff[5:4]};
    end else begin
      nxt_t2 = t2_ff + 10'h001;
    end
  end

  // ------------------------------------------------------------
  // output steering
  // ------------------------------------------------------------
  reg [3:0] drive;  // pins owned by the unit
  reg [3:0] lvl;    // their levels
  wire acl = unit_mode_select[1];  // pins a and c active low outside single output
  wire bdl = unit_mode_select[0];  // pins b and d active low
  wire pw  = pwm_raw_ff;

  // pick the subset of pins for the mode
  always @* begin
    drive = 4'h0;
    lvl   = 4'h0;
    if (pwm_md) begin
      case (pwm_output_config)
        `OCFG_SINGLE: begin
          drive = 4'b0001;
          lvl   = {3'b000, pw};
        end
        `OCFG_HALF: begin
          drive = 4'b0011;
          lvl   = {2'b00, ~pw ^ bdl, pw ^ acl};
        end
        `OCFG_FWD: begin
          drive = 4'b1111;
          lvl   = {pw ^ bdl, acl, bdl, ~acl};
        end
        `OCFG_REV: begin
          drive = 4'b1111;
          lvl   = {bdl, ~acl, pw ^ bdl, acl};
        end
        default: lvl = 4'h0;
      endcase
    end else if ((unit_mode_select == `MODE_CMP_TGL) |
                 (unit_mode_select == `MODE_CMP_SET) |
                 (unit_mode_select == `MODE_CMP_CLR)) begin
      // compare output uses the compatible pin only
      drive = 4'b0001;
      lvl   = {3'b000, cmp_pin_ff};
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  reg [31:0] rd_word;

  // unused upper bits read as zero
  always @* begin
    case (PADDR)
      `OFS_CTRL: rd_word = {24'h000000, ctrl_ff};
      `OFS_CMP:  rd_word = {16'h0000, cmp_ff};
      `OFS_T1:   rd_word = {16'h0000, t1_ff};
      `OFS_T3:   rd_word = {16'h0000, t3_ff};
      `OFS_CFG:  rd_word = {28'h0000000, cfg_ff};
      `OFS_PWM:  rd_word = {16'h0000, pwm_ff};
      `OFS_DIR:  rd_word = {28'h0000000, dir_ff};
      `OFS_STAT: rd_word = {16'h0000, t2_ff[9:2], 7'h00, flag_ff};
      `OFS_CAPT: rd_word = {16'h0000, capt_ff};
      default:   rd_word = 32'h00000000;
    endcase
  end

  // ------------------------------------------------------------
  // registers and timers
  // ------------------------------------------------------------
  always @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_ff      <= `RST_CTRL;
      cmp_ff       <= 16'h0000;
      t1_ff        <= 16'h0000;
      t3_ff        <= 16'h0000;
      cfg_ff       <= `RST_CFG;
      pwm_ff       <= `RST_PWM;
      dir_ff       <= `RST_DIR;
      flag_ff      <= 1'b0;
      capt_ff      <= 16'h0000;
      prdata_ff    <= 32'h00000000;
      slverr_ff    <= 1'b0;
      sync_ff      <= 3'b000;
      filt_ff      <= 1'b0;
      filt_prev_ff <= 1'b0;
      pre_ff       <= 4'h0;
      eq_ff        <= 1'b0;
      cmp_pin_ff   <= 1'b0;
      t2_ff        <= 10'h000;
      duty_ff      <= 10'h000;
      pwm_raw_ff   <= 1'b0;
      out_ff       <= 4'h0;
      oe_n_ff      <= 4'hf;
      trig_ff      <= 1'b0;
    end else begin
      // read data and error are fixed in the setup cycle
      if (setup) begin
        prdata_ff <= rd_word;
        slverr_ff <= ~addr_ok(PADDR);
      end
      if (wr_ctrl) begin
        ctrl_ff <= PWDATA[7:0];
      end
      if (wr_cmp) begin
        cmp_ff <= PWDATA[15:0];
      end
      if (wr_cfg) begin
        cfg_ff <= PWDATA[3:0];
      end
      if (wr_pwm) begin
        pwm_ff <= PWDATA[15:0];
      end
      if (wr_dir) begin
        dir_ff <= PWDATA[3:0];
      end
      // only the selected timer is cleared by the trigger, and it
      // clears on the edge that sets the flag
      t1_ff <= tmr_next(t1_ff, cfg_ff[`CFG_T1_EN], sp_clr & ~tsel,
                        wr_t1, PWDATA[15:0]);
      t3_ff <= tmr_next(t3_ff, cfg_ff[`CFG_T3_EN], sp_clr & tsel,
                        wr_t3, PWDATA[15:0]);
      // set wins over a write-one clear in the same cycle
      flag_ff <= fire | (cap_md & cap_hit) |
                 (flag_ff & ~(wr_stat & PWDATA[`STAT_FLAG]));
      trig_ff <= sp_clr;
      eq_ff   <= eq;
      // capture pin: third stage must agree with second
      sync_ff <= {sync_ff[1:0], CAP_IN};
      if (sync_ff[1] == sync_ff[2]) begin
        filt_ff <= sync_ff[2];
      end
      filt_prev_ff <= filt_ff;
      if (cap_md & cap_hit) begin
        capt_ff <= sel_tmr;
      end
      // prescaler restarts on any mode write
      if (wr_ctrl | ~cap_md) begin
        pre_ff <= 4'h0;
      end else if (rise) begin
        pre_ff <= pre_ff + 4'h1;
      end
      // compare latch: preset on mode write, then act on match
      if (wr_ctrl) begin
        cmp_pin_ff <= (PWDATA[3:0] == `MODE_CMP_CLR);
      end else if (fire) begin
        case (unit_mode_select)
          `MODE_CMP_TGL: cmp_pin_ff <= ~cmp_pin_ff;
          `MODE_CMP_SET: cmp_pin_ff <= 1'b1;
          `MODE_CMP_CLR: cmp_pin_ff <= 1'b0;
          default:       cmp_pin_ff <= cmp_pin_ff;
        endcase
      end
      t2_ff      <= nxt_t2;
      duty_ff    <= nxt_duty;
      pwm_raw_ff <= t2_run & (nxt_t2 < nxt_duty);
      // a pin is driven only when the unit owns it and its
      // direction bit says output
      out_ff  <= lvl & drive & ~dir_ff;
      oe_n_ff <= ~(drive & ~dir_ff);
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign PRDATA    = prdata_ff;
  assign PREADY    = 1'b1;  // no wait states
  assign PSLVERR   = slverr_ff;
  assign PWM_OUT_A = out_ff[0];
  assign PWM_OUT_B = out_ff[1];
  assign PWM_OUT_C = out_ff[2];
  assign PWM_OUT_D = out_ff[3];
  assign PWM_OE_N  = oe_n_ff;
  assign TRIG_OUT  = trig_ff;

endmodule
`default_nettype wire

//--- rtl/eccp_out_map.vh
`ifndef ECCP_OUT_MAP_VH
`define ECCP_OUT_MAP_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_CMP       8'h04
`define OFS_T1        8'h08
`define OFS_T3        8'h0c
`define OFS_CFG       8'h10
`define OFS_PWM       8'h14
`define OFS_DIR       8'h18
`define OFS_STAT      8'h1c
`define OFS_CAPT      8'h20
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CFG_T1_EN     0
`define CFG_T3_EN     1
`define CFG_TSEL      2
`define CFG_T2_EN     3
`define STAT_FLAG     0
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_CTRL      8'h00
`define RST_CFG       4'h0
`define RST_PWM       16'h00ff
`define RST_DIR       4'hf
// ------------------------------------------------------------
// unit modes
// ------------------------------------------------------------
`define MODE_OFF      4'h0
`define MODE_CMP_TGL  4'h2
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_4    4'h6
`define MODE_CAP_16   4'h7
`define MODE_CMP_SET  4'h8
`define MODE_CMP_CLR  4'h9
`define MODE_CMP_SOFT 4'ha
`define MODE_CMP_TRIG 4'hb
// ------------------------------------------------------------
// output configurations
// ------------------------------------------------------------
`define OCFG_SINGLE   2'b00
`define OCFG_FWD      2'b01
`define OCFG_HALF     2'b10
`define OCFG_REV      2'b11
`endif

//--- tb/pwm_load.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_load (
  // pin drive from the unit
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] oe_n,
  // level seen at the load
  output wire logic [3:0] level
);
  // ----------------------------------------------------------
  // pull-down loads
  // ----------------------------------------------------------
  // a released pin sinks to low, never holds its last drive
  assign level = ~oe_n & pin_out;
endmodule
`default_nettype wire

//--- tb/eccp_out_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "eccp_out_map.vh"
module eccp_out_monitor (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // pins
  input wire logic        CAP_IN,
  input wire logic        PWM_OUT_A,
  input wire logic        PWM_OUT_B,
  input wire logic        PWM_OUT_C,
  input wire logic        PWM_OUT_D,
  input wire logic [3:0]  PWM_OE_N,
  input wire logic        TRIG_OUT
);
  // ----------------------------------------------------------
  // shadow of the control word
  // ----------------------------------------------------------
  logic [7:0] ctrl_ff;  // control word as last written
  wire  [7:0] nxt_ctrl = !RST_N ? 8'h00 :
    (PSEL && PENABLE && PWRITE && PADDR == `OFS_CTRL) ? PWDATA[7:0] : ctrl_ff;
  // pins lag the control word by one cycle, hence the two-cycle windows
  always_ff @(posedge CLK) ctrl_ff <= nxt_ctrl;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  ready_always_a: assert property (PREADY) else $error("ready low");
  err_decode_a: assert property (PSEL && !PENABLE |=> PSLVERR ==
    ($past(PADDR) > 8'h20 || ($past(PADDR) & 8'h03) != 8'h00)) else $error("bad decode");
  err_zero_a: assert property (PSLVERR |-> PRDATA == 32'h0) else $error("error data");
  released_low_a: assert property (
    (PWM_OE_N & {PWM_OUT_D, PWM_OUT_C, PWM_OUT_B, PWM_OUT_A}) == 4'h0) else $error("drive");
  idle_pins_a: assert property (
    ctrl_ff[3:2] != 2'b11 [*2] |-> PWM_OE_N[3:1] == 3'b111) else $error("idle pins");
  single_pin_a: assert property (
    (ctrl_ff[7:6] == 2'b00 && ctrl_ff[3:2] == 2'b11) [*2] |-> PWM_OE_N[3:1] == 3'b111)
    else $error("single pins");
  half_owned_a: assert property (
    ctrl_ff[7:6] == 2'b10 [*2] |-> PWM_OE_N[3:2] == 2'b11) else $error("half pins");
  half_pair_a: assert property (
    (ctrl_ff == 8'h8c) [*2] ##0 (PWM_OE_N[1:0] == 2'b00) |-> PWM_OUT_B == !PWM_OUT_A)
    else $error("half pair");
  fwd_drive_a: assert property (
    (ctrl_ff == 8'h4c) [*2] ##0 (PWM_OE_N == 4'h0) |-> PWM_OUT_A && !PWM_OUT_B && !PWM_OUT_C)
    else $error("forward levels");
  trig_pulse_a: assert property (TRIG_OUT |=> !TRIG_OUT) else $error("trig width");
  trig_mode_a: assert property (
    TRIG_OUT |-> ctrl_ff[3:0] == `MODE_CMP_TRIG) else $error("trig mode");
  cover property (TRIG_OUT);
  cover property (PWM_OE_N == 4'h0);
  cover property (PSLVERR);
  cover property (ctrl_ff == 8'h8c);
endmodule
bind eccp_out eccp_out_monitor eccp_out_monitor_i (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .CAP_IN(CAP_IN), .PWM_OUT_A(PWM_OUT_A),
  .PWM_OUT_B(PWM_OUT_B), .PWM_OUT_C(PWM_OUT_C), .PWM_OUT_D(PWM_OUT_D),
  .PWM_OE_N(PWM_OE_N), .TRIG_OUT(TRIG_OUT));
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "eccp_out_map.vh"
module tb;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic        clk, rst_n, psel, penable, pwrite, cap_in, seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rdata;
  wire  [31:0] prdata;
  wire         pready, pslverr, out_a, out_b, out_c, out_d, trig_out;
  wire  [3:0]  oe_n, level;
  int          mismatches, checks;
  // expected enables and levels per output config, duty zero and full
  logic [3:0]  oe_tab[4] = '{4'he, 4'h0, 4'hc, 4'h0};
  logic [3:0]  lo_tab[4] = '{4'h0, 4'h1, 4'h2, 4'h4};
  logic [3:0]  hi_tab[4] = '{4'h1, 4'h9, 4'h1, 4'h6};
  eccp_out eccp_out_i (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CAP_IN(cap_in), .PWM_OUT_A(out_a), .PWM_OUT_B(out_b),
    .PWM_OUT_C(out_c), .PWM_OUT_D(out_d), .PWM_OE_N(oe_n), .TRIG_OUT(trig_out));
  pwm_load pwm_load_i (.pin_out({out_d, out_c, out_b, out_a}), .oe_n(oe_n), .level(level));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------
  // one apb transfer; idles a cycle after so strobes never retoggle in one step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog: the tests need about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim;
  end
  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, cap_in, paddr, pwdata} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    xfer(0, `OFS_PWM, 0);
    chk("pwm reset", rdata, 32'h00ff);
    xfer(0, `OFS_DIR, 0);
    chk("dir reset", rdata, 32'hf);
    chk("oe reset", oe_n, 4'hf);
    // unmapped then misaligned address
    for (int i = 0; i < 2; i++) begin
      xfer(0, i ? 8'h02 : 8'h24, 0);
      chk("slverr", pslverr, 1);
      chk("err data", rdata, 0);
    end
    // trigger on timer one, on timer three, then flag-only compare
    for (int k = 0; k < 3; k++) begin
      xfer(1, `OFS_CFG, 0);
      xfer(1, `OFS_CTRL, k == 2 ? `MODE_CMP_SOFT : `MODE_CMP_TRIG);
      xfer(1, `OFS_CMP, 32'h20);
      xfer(1, `OFS_T1, 0);
      xfer(1, `OFS_T3, 0);
      xfer(1, `OFS_STAT, 1);
      xfer(1, `OFS_CFG, k == 1 ? 32'h7 : 32'h3);
      seen = 1'b0;
      for (int n = 0; n < 60 && !seen; n++) begin
        @(posedge clk);
        seen = trig_out;
      end
      chk("trigger", seen, k != 2);
      xfer(0, k == 1 ? `OFS_T3 : `OFS_T1, 0);
      chk("selected restart", rdata < 32'h20, k != 2);
      xfer(0, k == 1 ? `OFS_T1 : `OFS_T3, 0);
      chk("other runs", rdata > 32'h20, 1);
      xfer(0, `OFS_STAT, 0);
      chk("match flag", rdata[0], 1);
    end
    // pin ownership and levels for every output config
    xfer(1, `OFS_CFG, 32'h8);
    xfer(1, `OFS_DIR, 0);
    for (int d = 0; d < 2; d++) begin
      xfer(1, `OFS_PWM, d ? 32'hff03 : 32'h0003);
      for (int c = 0; c < 4; c++) begin
        xfer(1, `OFS_CTRL, {c[1:0], 6'h0c});
        repeat (40) @(posedge clk);
        chk("pin enables", oe_n, oe_tab[c]);
        chk("pin levels", level, d ? hi_tab[c] : lo_tab[c]);
      end
    end
    xfer(1, `OFS_DIR, 32'hf);
    repeat (4) @(posedge clk);
    chk("dir input", oe_n, 4'hf);
    xfer(1, `OFS_DIR, 0);
    xfer(1, `OFS_CTRL, `MODE_OFF);
    repeat (4) @(posedge clk);
    chk("mode off", oe_n, 4'hf);
    // capture on a rising then a falling pin edge, timer one running
    xfer(1, `OFS_CFG, 32'h1);
    xfer(1, `OFS_CMP, 32'h40);
    for (int e = 0; e < 2; e++) begin
      xfer(1, `OFS_STAT, 1);
      xfer(1, `OFS_CTRL, e ? `MODE_CAP_FALL : `MODE_CAP_RISE);
      xfer(1, `OFS_T1, 0);
      repeat (20) @(posedge clk);
      cap_in <= !e;
      // the pin passes the synchroniser, so the count lands a few ticks on
      repeat (10) @(posedge clk);
      xfer(0, `OFS_CAPT, 0);
      chk("capture time", rdata > 32'h14 && rdata < 32'h24, 1);
      xfer(0, `OFS_STAT, 0);
      chk("capture flag", rdata[0], 1);
    end
    // compare pin: clear, set and toggle on a match of timer one
    for (int m = 0; m < 3; m++) begin
      xfer(1, `OFS_T1, 0);
      xfer(1, `OFS_CTRL, m == 0 ? `MODE_CMP_CLR : m == 1 ? `MODE_CMP_SET : `MODE_CMP_TGL);
      repeat (2) @(posedge clk);
      chk("pin preset", level, m == 0);
      repeat (80) @(posedge clk);
      chk("pin on match", level, m != 0);
    end
    // reset in mid-run drops the pins and the mode at once
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset pins", oe_n, 4'hf);
    xfer(0, `OFS_CTRL, 0);
    chk("reset mode", rdata, 0);
    end_sim;
  end
endmodule
`default_nettype wire
